// File: hdl/ipw_defs.svh
// Timing constants of the isolated pulse link port.
// Assumes a 50 ns system clock; counts derive from the times.
`ifndef IPW_DEFS_SVH
`define IPW_DEFS_SVH

// ==========================================================
// Clock and pulse shape
`define IPW_CLK_NS 50
`define IPW_SHORT_HALF_NS 50
`define IPW_LONG_HALF_NS 150
`define IPW_SHORT_HALF_CYC (`IPW_SHORT_HALF_NS / `IPW_CLK_NS)
`define IPW_LONG_HALF_CYC (`IPW_LONG_HALF_NS / `IPW_CLK_NS)
// Long when first half lasts at least this many cycles
`define IPW_LONG_THRESH_CYC ((`IPW_SHORT_HALF_CYC + `IPW_LONG_HALF_CYC) / 2)

// ==========================================================
// Wake detection and link timers
`define IPW_DWELL_NS 240
`define IPW_DWELL_CYC ((`IPW_DWELL_NS + `IPW_CLK_NS - 1) / `IPW_CLK_NS)
`define IPW_BLACKOUT_NS 2000
`define IPW_BLACKOUT_CYC ((`IPW_BLACKOUT_NS + `IPW_CLK_NS - 1) / `IPW_CLK_NS)
`define IPW_READY_US 10
`define IPW_READY_CYC ((`IPW_READY_US * 1000) / `IPW_CLK_NS)
`define IPW_WAKE_US 400
`define IPW_IDLE_US 4000
`define IPW_RESP_WIN_CYC 8

`endif

// File: hdl/ipw_pkg.sv
// Types shared by the pulse link port and its line front end.
// Assumes ipw_defs.svh holds all numeric constants.
package ipw_pkg;

  // ==========================================================
  // Link port states
  typedef enum logic [1:0] {
    ST_SLEEP  = 2'b00,
    ST_WAKING = 2'b01,
    ST_READY  = 2'b10,
    ST_ACTIVE = 2'b11
  } link_state_t;

  // One pulse symbol: neg marks a -1 pulse, long_p a long one
  typedef struct packed {
    logic valid;
    logic neg;
    logic long_p;
  } pulse_t;

  // Differential drive of one port
  typedef struct packed {
    logic pos;
    logic neg;
  } line_drv_t;

endpackage

// File: hdl/ipw_port_phy.sv
// Line front end for one pulse link port: receive, transmit, wake.
// Assumes comparator levels arrive asynchronously on the raw inputs.
`timescale 1ns/1ps
`default_nettype none
`include "ipw_defs.svh"

module ipw_port_phy (
  input wire logic i_mclk,              // System clock
  input wire logic i_rst_n,             // Synchronised reset
  input wire logic i_ce,                // Clock enable
  input wire logic i_line_pos,          // Line above positive threshold
  input wire logic i_line_neg,          // Line below negative threshold
  input wire ipw_pkg::pulse_t i_tx,     // Pulse to send
  output logic o_tx_busy,               // Transmitter running
  output ipw_pkg::line_drv_t o_drv,     // Line drive levels
  output ipw_pkg::pulse_t o_rx,         // Received pulse, one cycle
  output logic o_wake                   // Qualified wake excursion
);

  localparam logic [2:0] HALF_S = 3'(`IPW_SHORT_HALF_CYC);
  localparam logic [2:0] HALF_L = 3'(`IPW_LONG_HALF_CYC);
  localparam logic [2:0] THR = 3'(`IPW_LONG_THRESH_CYC);
  localparam logic [2:0] DWELL = 3'(`IPW_DWELL_CYC);

  logic pos_s1_q, pos_s2_q, neg_s1_q, neg_s2_q;
  logic lvl_pos, lvl_neg, diff;
  logic [2:0] dwell_q, len_q, left_q, half_q;
  logic [1:0] mute_q;
  logic in_first_q, first_neg_q, quiet_wait_q;

  // ==========================================================
  // Input synchronisers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_s1_q <= 1'b0;
      pos_s2_q <= 1'b0;
      neg_s1_q <= 1'b0;
      neg_s2_q <= 1'b0;
    end else if (i_ce) begin
      pos_s1_q <= i_line_pos;
      pos_s2_q <= pos_s1_q;
      neg_s1_q <= i_line_neg;
      neg_s2_q <= neg_s1_q;
    end
  end

  // Common-mode (both comparators) is not a differential level
  assign lvl_pos = pos_s2_q & ~neg_s2_q;
  assign lvl_neg = neg_s2_q & ~pos_s2_q;
  assign diff = (lvl_pos | lvl_neg) & (mute_q == 2'd0);

  // ==========================================================
  // Wake qualifier: differential level held for the dwell time
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dwell_q <= 3'h0;
      o_wake <= 1'b0;
    end else if (i_ce) begin
      o_wake <= diff && (dwell_q == DWELL - 3'd1);
      if (!diff) begin
        dwell_q <= 3'h0;
      end else if (dwell_q != DWELL) begin
        dwell_q <= dwell_q + 3'd1;
      end
    end
  end

  // ==========================================================
  // Receiver: classify by first-half length, report at polarity flip
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_first_q <= 1'b0;
      first_neg_q <= 1'b0;
      quiet_wait_q <= 1'b0;
      len_q <= 3'h0;
      o_rx <= '0;
    end else if (i_ce) begin
      o_rx <= '0;
      if (mute_q != 2'd0) begin
        in_first_q <= 1'b0;
        quiet_wait_q <= 1'b0;
      end else if (quiet_wait_q) begin
        quiet_wait_q <= lvl_pos | lvl_neg;
      end else if (!in_first_q) begin
        if (lvl_pos | lvl_neg) begin
          in_first_q <= 1'b1;
          first_neg_q <= lvl_neg;
          len_q <= 3'd1;
        end
      end else if ((first_neg_q && lvl_neg) || (!first_neg_q && lvl_pos)) begin
        if (len_q != 3'h7) begin
          len_q <= len_q + 3'd1;
        end
      end else if (lvl_pos | lvl_neg) begin
        o_rx.valid <= 1'b1;
        o_rx.neg <= first_neg_q;
        o_rx.long_p <= (len_q >= THR);
        in_first_q <= 1'b0;
        quiet_wait_q <= 1'b1;
      end else begin
        in_first_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Transmitter: two opposite halves, line back to zero
  assign o_tx_busy = (left_q != 3'h0);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      left_q <= 3'h0;
      half_q <= 3'h0;
      o_drv <= '0;
      mute_q <= 2'd0;
    end else if (i_ce) begin
      if (o_tx_busy || i_tx.valid) begin
        mute_q <= 2'd3; // Own echo masked through the synchroniser
      end else if (mute_q != 2'd0) begin
        mute_q <= mute_q - 2'd1;
      end
      if (i_tx.valid && !o_tx_busy) begin
        half_q <= i_tx.long_p ? HALF_L : HALF_S;
        left_q <= i_tx.long_p ? 3'(HALF_L * 2) : 3'(HALF_S * 2);
        o_drv.pos <= ~i_tx.neg;
        o_drv.neg <= i_tx.neg;
      end else if (o_tx_busy) begin
        left_q <= left_q - 3'd1;
        if (left_q == half_q + 3'd1) begin
          o_drv.pos <= o_drv.neg;
          o_drv.neg <= o_drv.pos;
        end else if (left_q == 3'd1) begin
          o_drv <= '0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: hdl/isolated_pulse_port_wake.sv
// Reversible two-port pulse link slave with wake, idle and relay logic.
// Assumes analog comparators on each port and a core that decodes reads.
//
// Contract
// - Received pulses drive internal select, data, clock
// - Read bit zero answered with short -1
// - Slave port sends only short -1 pulses
// - Pulse mode accepts traffic on either port
// - Sleeping device wakes from either port; the code takes a first-port wake only in pulse-link mode
// - First-port wake sends long +1 upward
// - Long -1 in ready picks slave port
// - Active holds select; slave long +1 ends
// - Master long -1 after blackout swaps ports
// - Master long pulse inside blackout ignored
// - Core decodes read after command and check
// - Own data first, then higher devices
// - No activity for idle timeout sleeps
// - Four-wire select or clock activity wakes
// - Differential activity wakes; common mode ignored
// - Wake needs excursion held for dwell time
// - Ready reached after wake or ready time
// - Becoming ready sends long +1 upward, except after a wake from the second port
// - Ready device does not relay wake
// - Master port encodes select and data pulses
// - Pulses are symmetric opposite half pairs
// - Bytes MSB first under held select
`timescale 1ns/1ps
`default_nettype none
`include "ipw_defs.svh"

module isolated_pulse_port_wake #(
  parameter int P_WAKE_CYC = (`IPW_WAKE_US * 1000) / `IPW_CLK_NS, // Sleep wake time
  parameter int P_IDLE_CYC = (`IPW_IDLE_US * 1000) / `IPW_CLK_NS  // Idle timeout
) (
  input wire logic i_mclk,                 // 20 MHz clock
  input wire logic i_arst_n,               // Async reset, active low
  input wire logic i_ce,                   // Clock enable
  input wire logic i_first_port_mode_select, // 1: first port is pulse link
  input wire logic i_core_sleep,           // Core asleep, else standby
  input wire logic i_chip_select_n,        // Four-wire select pin
  input wire logic i_spi_sck,              // Four-wire clock pin
  input wire logic [1:0] i_line_pos,       // Per port positive comparator
  input wire logic [1:0] i_line_neg,       // Per port negative comparator
  input wire logic i_sdo,                  // Core read data bit
  input wire logic i_read_own,             // Core shifting its own data
  input wire logic i_read_chain,           // Read passing higher data
  output ipw_pkg::line_drv_t [1:0] o_drv,  // Per port line drive
  output logic o_chip_select_n,            // Internal select
  output logic o_sdi,                      // Internal data in
  output logic o_sck,                      // Internal clock pulse
  output ipw_pkg::link_state_t o_state,    // Link state
  output logic o_slave_port                // Index of slave port
);

  localparam logic [5:0] BLOCK_CYC = 6'(`IPW_BLACKOUT_CYC);
  localparam logic [3:0] RESP_CYC = 4'(`IPW_RESP_WIN_CYC);
  localparam int WW = $clog2(P_WAKE_CYC + `IPW_READY_CYC + 1);
  localparam int IW = $clog2(P_IDLE_CYC + 1);
  localparam logic [WW-1:0] WAKE_END = WW'(P_WAKE_CYC - 1);
  localparam logic [WW-1:0] READY_END = WW'(`IPW_READY_CYC - 1);
  localparam logic [IW-1:0] IDLE_END = IW'(P_IDLE_CYC - 1);

  logic rst_s1_q, rst_n;
  logic cs_s1_q, cs_s2_q, cs_s3_q, sck_s1_q, sck_s2_q, sck_s3_q;
  logic spi_act;
  ipw_pkg::link_state_t state_q;
  logic slave_q, master, woke_first_q;
  logic [WW-1:0] wait_q;
  logic [IW-1:0] idle_q;
  logic [5:0] block_q;
  logic [3:0] resp_q;
  logic saw_neg_q, sck_arm_q;
  logic wait_done, idle_done, any_pulse, ret_bit;
  ipw_pkg::pulse_t rx [2];
  ipw_pkg::pulse_t rx_en [2];
  ipw_pkg::pulse_t tx_req [2];
  logic [1:0] busy, wake;
  ipw_pkg::pulse_t srx, mrx;

  // ==========================================================
  // Reset release
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ==========================================================
  // Four-wire pin synchronisers and activity edges
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
    end else if (i_ce) begin
      cs_s1_q <= i_chip_select_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      sck_s1_q <= i_spi_sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end

  assign spi_act = ~i_first_port_mode_select &
                   ((cs_s2_q ^ cs_s3_q) | (sck_s2_q ^ sck_s3_q));

  // ==========================================================
  // Line front ends, one per port
  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      ipw_port_phy u_phy (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_line_pos(i_line_pos[p]),
        .i_line_neg(i_line_neg[p]),
        .i_tx(tx_req[p]),
        .o_tx_busy(busy[p]),
        .o_drv(o_drv[p]),
        .o_rx(rx[p]),
        .o_wake(wake[p])
      );
      // First port carries pulses only in pulse-link mode
      assign rx_en[p] = (p == 0 && !i_first_port_mode_select) ? '0 : rx[p];
    end
  endgenerate

  assign master = ~slave_q;
  assign srx = slave_q ? rx_en[1] : rx_en[0];
  assign mrx = slave_q ? rx_en[0] : rx_en[1];
  assign wait_done = (state_q == ipw_pkg::ST_WAKING) &&
                     (wait_q == (i_core_sleep ? WAKE_END : READY_END));
  assign idle_done = (idle_q == IDLE_END);
  assign any_pulse = rx_en[0].valid | rx_en[1].valid | (|busy) | spi_act;
  // Own data from the core, else what the master port returned
  assign ret_bit = i_read_own ? i_sdo : ~saw_neg_q;

  // ==========================================================
  // Port state machine
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ipw_pkg::ST_SLEEP;
      slave_q <= 1'b0;
      woke_first_q <= 1'b0;
      o_chip_select_n <= 1'b1;
    end else if (i_ce) begin
      case (state_q)
        ipw_pkg::ST_SLEEP: begin
          if (wake[1] || (wake[0] && i_first_port_mode_select) || spi_act) begin
            state_q <= ipw_pkg::ST_WAKING;
            woke_first_q <= ~wake[1];
          end
        end
        ipw_pkg::ST_WAKING: begin
          if (wait_done) begin
            state_q <= ipw_pkg::ST_READY;
          end
        end
        ipw_pkg::ST_READY: begin
          if (rx_en[0].valid && rx_en[0].long_p && rx_en[0].neg) begin
            state_q <= ipw_pkg::ST_ACTIVE;
            slave_q <= 1'b0;
            o_chip_select_n <= 1'b0;
          end else if (rx_en[1].valid && rx_en[1].long_p && rx_en[1].neg) begin
            state_q <= ipw_pkg::ST_ACTIVE;
            slave_q <= 1'b1;
            o_chip_select_n <= 1'b0;
          end else if (idle_done) begin
            state_q <= ipw_pkg::ST_SLEEP;
          end
        end
        ipw_pkg::ST_ACTIVE: begin
          if (srx.valid && srx.long_p && !srx.neg) begin
            state_q <= ipw_pkg::ST_READY;
            o_chip_select_n <= 1'b1;
          end else if (mrx.valid && mrx.long_p && mrx.neg && block_q == 6'h0) begin
            slave_q <= master;
          end
        end
        default: begin
          state_q <= ipw_pkg::ST_SLEEP;
        end
      endcase
    end
  end

  // ==========================================================
  // Wake or ready time counter
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= '0;
    end else if (i_ce) begin
      if (state_q != ipw_pkg::ST_WAKING || wait_done) begin
        wait_q <= '0;
      end else begin
        wait_q <= wait_q + WW'(1);
      end
    end
  end

  // ==========================================================
  // Idle timer, counts only while ready and quiet
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= '0;
    end else if (i_ce) begin
      if (state_q != ipw_pkg::ST_READY || any_pulse || idle_done) begin
        idle_q <= '0;
      end else begin
        idle_q <= idle_q + IW'(1);
      end
    end
  end

  // ==========================================================
  // Blackout after own transmission on any port
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      block_q <= 6'h0;
    end else if (i_ce) begin
      if (|busy) begin
        block_q <= BLOCK_CYC;
      end else if (block_q != 6'h0) begin
        block_q <= block_q - 6'd1;
      end
    end
  end

  // ==========================================================
  // Internal data and clock from slave short pulses
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_sdi <= 1'b0;
      o_sck <= 1'b0;
      sck_arm_q <= 1'b0;
    end else if (i_ce) begin
      sck_arm_q <= (state_q == ipw_pkg::ST_ACTIVE) && srx.valid && !srx.long_p;
      o_sck <= sck_arm_q;
      if ((state_q == ipw_pkg::ST_ACTIVE) && srx.valid && !srx.long_p) begin
        o_sdi <= ~srx.neg;
      end
    end
  end

  // ==========================================================
  // Answer window: collect returned bit from master port
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      resp_q <= 4'h0;
      saw_neg_q <= 1'b0;
    end else if (i_ce) begin
      if ((state_q == ipw_pkg::ST_ACTIVE) && srx.valid && !srx.long_p) begin
        resp_q <= RESP_CYC;
        saw_neg_q <= 1'b0;
      end else begin
        if (resp_q != 4'h0) begin
          resp_q <= resp_q - 4'd1;
        end
        if (resp_q != 4'h0 && mrx.valid && !mrx.long_p && mrx.neg) begin
          saw_neg_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Transmit requests: wake relay, forwarding, read answers
  always_comb begin
    tx_req[0] = '0;
    tx_req[1] = '0;
    if (wait_done && woke_first_q) begin
      tx_req[1] = '{valid: 1'b1, neg: 1'b0, long_p: 1'b1};
    end else if (state_q == ipw_pkg::ST_READY) begin
      // Relay select assertion out of the other port
      if (rx_en[0].valid && rx_en[0].long_p && rx_en[0].neg) begin
        tx_req[1] = rx_en[0];
      end else if (rx_en[1].valid && rx_en[1].long_p && rx_en[1].neg) begin
        tx_req[0] = rx_en[1];
      end
    end else if (state_q == ipw_pkg::ST_ACTIVE) begin
      if (srx.valid) begin
        tx_req[master] = srx;
      end else if (mrx.valid && mrx.long_p && mrx.neg && block_q == 6'h0) begin
        tx_req[slave_q] = mrx;
      end
      if (resp_q == 4'd1 && (i_read_own || i_read_chain) && !ret_bit) begin
        tx_req[slave_q] = '{valid: 1'b1, neg: 1'b1, long_p: 1'b0};
      end
    end
  end

  assign o_state = state_q;
  assign o_slave_port = slave_q;

endmodule
`default_nettype wire

// File: verification/link_far_end.sv
// Far-end line model: drives one port's comparator levels, decodes its drive.
// Assumes tasks start at a falling edge.
`timescale 1ns/1ps
`default_nettype none

module link_far_end (
  input wire logic i_mclk,              // Clock
  input wire ipw_pkg::line_drv_t i_drv, // Port drive
  output logic o_pos,                   // Line positive
  output logic o_neg,                   // Line negative
  output int o_ret_neg,                 // Short -1 seen
  output int o_short_pos,               // Short +1 seen
  output int o_long_pos,                // Long +1 seen
  output int o_long_neg                 // Long -1 seen
);
  logic first_neg;
  logic second;
  int run;

  // Terminated line rests at zero volts
  initial begin
    o_pos = 1'b0;
    o_neg = 1'b0;
    o_ret_neg = 0;
    o_short_pos = 0;
    o_long_pos = 0;
    o_long_neg = 0;
    run = 0;
  end

  // Opposite halves of equal length, long ones outlast the wake dwell
  task automatic send(input logic neg, input logic long_p);
    int n;
    n = long_p ? 3 : 1;
    o_pos = !neg;
    o_neg = neg;
    repeat (n) @(negedge i_mclk);
    o_pos = neg;
    o_neg = !neg;
    repeat (n) @(negedge i_mclk);
    o_pos = 1'b0;
    o_neg = 1'b0;
  endtask

  // Both comparators high: common-mode disturbance
  task automatic common(input int n);
    o_pos = 1'b1;
    o_neg = 1'b1;
    repeat (n) @(negedge i_mclk);
    o_pos = 1'b0;
    o_neg = 1'b0;
  endtask

  // Classify drive pulses; silence reads as one
  always @(posedge i_mclk) begin
    if (i_drv.pos ^ i_drv.neg) begin
      if (run == 0) begin
        first_neg = i_drv.neg;
        second = 1'b0;
        run = 1;
      end else if (!second && i_drv.neg == first_neg) begin
        run++;
      end else if (!second) begin
        second = 1'b1;
        case ({first_neg, run >= 3})
          2'b10: o_ret_neg++;
          2'b00: o_short_pos++;
          2'b01: o_long_pos++;
          default: o_long_neg++;
        endcase
      end
    end else begin
      run = 0;
    end
  end
endmodule

`default_nettype wire

// File: verification/isolated_pulse_port_wake_props.sv
// Checker of the pulse link port, bound to the top module.
// Assumes a ready time of 200 cycles.
`timescale 1ns/1ps
`default_nettype none

module isolated_pulse_port_wake_props #(
  parameter int P_WAKE_CYC = 8000,
  parameter int P_IDLE_CYC = 80000
) (
  input wire logic i_mclk,                   // Clock
  input wire logic i_arst_n,                 // Reset
  input wire logic i_ce,                     // Enable
  input wire logic i_first_port_mode_select, // Mode
  input wire logic i_core_sleep,             // Core sleep
  input wire logic i_chip_select_n,          // Select pin
  input wire logic i_spi_sck,                // Clock pin
  input wire logic [1:0] i_line_pos,         // Positive levels
  input wire logic [1:0] i_line_neg,         // Negative levels
  input wire logic i_sdo,                    // Read bit
  input wire logic i_read_own,               // Own read
  input wire logic i_read_chain,             // Chain read
  input wire ipw_pkg::line_drv_t [1:0] o_drv, // Drive
  input wire logic o_chip_select_n,          // Select
  input wire logic o_sdi,                    // Data
  input wire logic o_sck,                    // Clock pulse
  input wire ipw_pkg::link_state_t o_state,  // State
  input wire logic o_slave_port              // Slave index
);
  localparam int WAIT_MAX = ((P_WAKE_CYC > 200) ? P_WAKE_CYC : 200) + 2;
  logic [31:0] wait_q;
  logic [31:0] quiet_q;
  wire logic busy = (|i_line_pos) | (|i_line_neg) | (|o_drv);

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  // Cycles spent waking, and quiet cycles in ready
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_q <= '0;
      quiet_q <= '0;
    end else begin
      wait_q <= (o_state == ipw_pkg::ST_WAKING) ? wait_q + 1 : '0;
      quiet_q <= (o_state == ipw_pkg::ST_READY && !busy) ? quiet_q + 1 : '0;
    end
  end

  // ==========================================================
  // Properties
  a_sck_single: assert property (o_sck |=> !o_sck)
    else $error("internal clock high two cycles");
  a_drive_exclusive: assert property (!(o_drv[0].pos && o_drv[0].neg)
    && !(o_drv[1].pos && o_drv[1].neg)) else $error("both drive levels on");
  a_select_active: assert property (o_state == ipw_pkg::ST_ACTIVE |-> !o_chip_select_n)
    else $error("select high while active");
  a_select_ready: assert property (o_state == ipw_pkg::ST_READY |-> o_chip_select_n)
    else $error("select low while ready");
  a_slave_short_neg: assert property (o_state == ipw_pkg::ST_ACTIVE && $stable(o_slave_port)
    && $rose(o_drv[o_slave_port].neg) |=> o_drv[o_slave_port].pos ##1 o_drv[o_slave_port] == '0)
    else $error("slave port sent other than short minus");
  a_slave_no_pos: assert property (o_state == ipw_pkg::ST_ACTIVE && $stable(o_slave_port)
    && $past(o_state) == ipw_pkg::ST_ACTIVE && $rose(o_drv[o_slave_port].pos)
    |-> $past(o_drv[o_slave_port].neg)) else $error("slave port sent plus pulse");
  a_pulse_shape: assert property ($rose(o_drv[1].pos) && !$past(o_drv[1].neg)
    |-> (o_drv[1].pos ##1 o_drv[1].neg ##1 !o_drv[1].neg)
    or (o_drv[1].pos [*3] ##1 o_drv[1].neg [*3] ##1 !o_drv[1].neg))
    else $error("bad pulse shape on second port");
  a_wake_bound: assert property (o_state == ipw_pkg::ST_WAKING |-> wait_q <= WAIT_MAX)
    else $error("waking too long");
  a_wake_exit: assert property ($past(o_state) == ipw_pkg::ST_WAKING
    && o_state != ipw_pkg::ST_WAKING |-> o_state == ipw_pkg::ST_READY)
    else $error("waking left for wrong state");
  a_idle_bound: assert property (quiet_q <= P_IDLE_CYC + 8)
    else $error("idle timeout missed");
  a_sleep_silent: assert property (o_state == ipw_pkg::ST_SLEEP |-> o_drv == '0)
    else $error("drive while asleep");
endmodule

bind isolated_pulse_port_wake isolated_pulse_port_wake_props #(
  .P_WAKE_CYC(P_WAKE_CYC),
  .P_IDLE_CYC(P_IDLE_CYC)
) u_isolated_pulse_port_wake_props (.*);

`default_nettype wire

// File: verification/tb_isolated_pulse_port_wake.sv
// Self-checking bench: two far-end line models, one on each port.
// Assumes package and design compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_isolated_pulse_port_wake;
  localparam int WAKE_CYC = 20;
  localparam int IDLE_CYC = 300;
  localparam int READY_CYC = 200;
  logic i_mclk, i_arst_n, i_ce, i_first_port_mode_select, i_core_sleep;
  logic i_chip_select_n, i_spi_sck, i_sdo, i_read_own, i_read_chain;
  wire logic [1:0] i_line_pos;
  wire logic [1:0] i_line_neg;
  ipw_pkg::line_drv_t [1:0] o_drv;
  logic o_chip_select_n, o_sdi, o_sck, o_slave_port;
  ipw_pkg::link_state_t o_state;
  int fails, tests_run, sck_seen;
  int ret0, sp0, lp0, ln0, ret1, sp1, lp1, ln1;

  isolated_pulse_port_wake #(.P_WAKE_CYC(WAKE_CYC), .P_IDLE_CYC(IDLE_CYC))
    u_isolated_pulse_port_wake (.*);
  link_far_end u_far_a (.i_mclk, .i_drv(o_drv[0]), .o_pos(i_line_pos[0]),
    .o_neg(i_line_neg[0]), .o_ret_neg(ret0), .o_short_pos(sp0), .o_long_pos(lp0),
    .o_long_neg(ln0));
  link_far_end u_far_b (.i_mclk, .i_drv(o_drv[1]), .o_pos(i_line_pos[1]),
    .o_neg(i_line_neg[1]), .o_ret_neg(ret1), .o_short_pos(sp1), .o_long_pos(lp1),
    .o_long_neg(ln1));

  // ==========================================================
  // Common tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  task automatic final_report;
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // Reset levels, then wake through the first port
  task automatic t_wake_first;
    chk({o_drv, o_chip_select_n, o_state}, 7'h04);
    u_far_a.send(1'b1, 1'b1);
    cyc(5);
    chk(o_state, ipw_pkg::ST_WAKING);
    cyc(WAKE_CYC + 15);
    chk(o_state, ipw_pkg::ST_READY);
    chk(lp1, 1);
    chk(lp0 + ln0 + sp0 + ret0, 0);
  endtask

  // Start, then both data symbols without a read
  task automatic t_data;
    u_far_a.send(1'b1, 1'b1);
    cyc(10);
    chk({o_state, o_slave_port, o_chip_select_n}, {ipw_pkg::ST_ACTIVE, 2'b00});
    chk(ln1, 1);
    for (int b = 0; b < 2; b++) begin
      u_far_a.send(b[0], 1'b0);
      cyc(14);
      chk({o_sdi, sck_seen[3:0]}, {!b[0], 4'(b + 1)});
      chk({sp1, ret1}, {32'd1, 32'(b)});
    end
    chk(ret0, 0);
  endtask

  // Own read: bit zero answered, bit one silent
  task automatic t_read;
    i_read_own = 1'b1;
    for (int b = 0; b < 2; b++) begin
      i_sdo = b[0];
      u_far_a.send(1'b0, 1'b0);
      cyc(16);
      chk(ret0, 1);
    end
    i_read_own = 1'b0;
  endtask

  // Master long -1 inside blackout ignored, later one swaps
  task automatic t_swap;
    u_far_a.send(1'b0, 1'b0);
    cyc(8);
    u_far_b.send(1'b1, 1'b1);
    cyc(10);
    chk({o_state, o_slave_port}, {ipw_pkg::ST_ACTIVE, 1'b0});
    cyc(50);
    u_far_b.send(1'b1, 1'b1);
    cyc(10);
    chk({o_state, o_slave_port}, {ipw_pkg::ST_ACTIVE, 1'b1});
    chk(ln0, 1);
  endtask

  // Slave long +1 ends; long +1 in ready is not relayed
  task automatic t_end;
    u_far_b.send(1'b0, 1'b1);
    cyc(10);
    chk({o_state, o_chip_select_n}, {ipw_pkg::ST_READY, 1'b1});
    chk(lp0, 1);
    cyc(50);
    u_far_a.send(1'b0, 1'b1);
    cyc(12);
    chk({o_state, lp1[3:0]}, {ipw_pkg::ST_READY, 4'h1});
  endtask

  // Idle to sleep, common mode, standby wake from the second port
  task automatic t_idle;
    cyc(IDLE_CYC - 30);
    chk(o_state, ipw_pkg::ST_READY);
    cyc(60);
    chk(o_state, ipw_pkg::ST_SLEEP);
    u_far_b.common(8);
    cyc(10);
    chk(o_state, ipw_pkg::ST_SLEEP);
    i_core_sleep = 1'b0;
    u_far_b.send(1'b1, 1'b1);
    cyc(READY_CYC - 20);
    chk(o_state, ipw_pkg::ST_WAKING);
    cyc(40);
    chk({o_state, lp0[3:0]}, {ipw_pkg::ST_READY, 4'h1});
  endtask

  // Four-wire select activity wakes and relays upward
  task automatic t_four_wire;
    i_core_sleep = 1'b1;
    cyc(IDLE_CYC + 40);
    chk(o_state, ipw_pkg::ST_SLEEP);
    i_first_port_mode_select = 1'b0;
    i_chip_select_n = 1'b0;
    cyc(3);
    i_chip_select_n = 1'b1;
    cyc(8);
    chk(o_state, ipw_pkg::ST_WAKING);
    cyc(WAKE_CYC + 15);
    chk({o_state, lp1[3:0]}, {ipw_pkg::ST_READY, 4'h2});
  endtask

  // ==========================================================
  // Clock, watchdog, internal clock monitor, main sequence
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  initial begin
    repeat (5000) @(posedge i_mclk);
    fails++;
    final_report();
  end

  always @(posedge i_mclk) begin
    if (o_sck === 1'b1) begin
      sck_seen++;
    end
  end

  initial begin
    i_arst_n = 1'b0;
    i_ce = 1'b1;
    i_first_port_mode_select = 1'b1;
    i_core_sleep = 1'b1;
    i_chip_select_n = 1'b1;
    i_spi_sck = 1'b0;
    i_sdo = 1'b1;
    i_read_own = 1'b0;
    i_read_chain = 1'b0;
    cyc(4);
    i_arst_n = 1'b1;
    cyc(4);
    t_wake_first();
    t_data();
    t_read();
    t_swap();
    t_end();
    t_idle();
    t_four_wire();
    final_report();
  end
endmodule

`default_nettype wire
